// *** include/cbx_pkg.sv ***
// Constants, command layout and types for the bit, shift, flag and load unit
package cbx_pkg;

  // ----------------------------------------------------------------
  // APB register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] STATUS_REGISTER_OFS   = 8'h08;
  localparam logic [7:0] PC_OFS     = 8'h0c;
  localparam logic [7:0] RD_OFS     = 8'h10;
  localparam logic [7:0] RR_OFS     = 8'h14;
  localparam logic [7:0] XPTR_OFS   = 8'h18;
  localparam logic [7:0] YPTR_OFS   = 8'h1c;
  localparam logic [7:0] MADDR_OFS  = 8'h20;
  localparam logic [7:0] MDATA_OFS  = 8'h24;
  localparam logic [7:0] IOADDR_OFS = 8'h28;
  localparam logic [7:0] IODATA_OFS = 8'h2c;

  // ----------------------------------------------------------------
  // Status register flag positions
  // ----------------------------------------------------------------
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ----------------------------------------------------------------
  // Reset values, cycle counts, pointer modes
  // ----------------------------------------------------------------
  localparam logic [7:0]  STATUS_REGISTER_RST  = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [15:0] PTR_RST   = 16'h0000;
  localparam logic [7:0]  CYC_ONE   = 8'h01;
  localparam logic [7:0]  CYC_TWO   = 8'h02;
  localparam logic [1:0]  PTR_PLAIN = 2'h0;
  localparam logic [1:0]  PTR_POST  = 2'h1;
  localparam logic [1:0]  PTR_PRE   = 2'h2;

  // Operation codes carried in the command word
  typedef enum logic [4:0] {
    OP_NOP, OP_BR_IRQ_ON, OP_BR_IRQ_OFF, OP_IO_SET, OP_IO_CLR,
    OP_LSL, OP_LSR, OP_ASR, OP_ROL, OP_ROR, OP_SWAP,
    OP_FLAG_SET, OP_FLAG_CLR, OP_BST, OP_BLD, OP_LD
  } cbx_op_t;

  // Command word as written to the command register
  typedef struct packed {
    logic [7:0] k_ofs;     // Signed branch offset
    logic [6:0] rsv;       // Unused, stored and read back at the command offset
    logic       ptr_sel;   // 0 selects X, 1 selects Y
    logic [1:0] ptr_mode;  // Plain, post-increment, pre-decrement
    logic [5:0] io_addr;   // I/O register index
    logic [2:0] bit_sel;   // Bit or flag index
    logic [4:0] op;        // Operation code
  } cbx_cmd_t;

  // Execution sequencer states
  typedef enum logic {ST_IDLE, ST_SECOND} cbx_state_t;

endpackage

// *** verilog/cbx_exec.sv ***
// Bit, shift, flag and indirect load execution unit with APB access
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps

module cbx_exec
  import cbx_pkg::*;
#(
  parameter int DM_AW = 8,  // Data memory address width
  parameter int IO_AW = 6   // I/O space address width
) (
  input  wire logic        mclk,         // Core clock, 100 MHz
  input  wire logic        resetn,       // Synchronous reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB direction, high writes
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error
  output logic             busy,         // Two-cycle op in progress
  output logic      [7:0]  status_flags, // Status register
  output logic      [15:0] prog_count    // Program counter
);

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [7:0]        dmem [0:(1<<DM_AW)-1];
  logic [7:0]        iomem [0:(1<<IO_AW)-1];
  cbx_state_t        state;
  cbx_cmd_t          cmd_q;
  logic [7:0]        rd;
  logic [7:0]        rr;
  logic [15:0]       xptr;
  logic [15:0]       yptr;
  logic [DM_AW-1:0]  maddr;
  logic [IO_AW-1:0]  ioaddr;
  logic [DM_AW-1:0]  ld_addr;
  logic [7:0]        cyc_last;
  logic              br_taken;

  // Combinational helpers
  logic              apb_acc;
  logic              take;
  logic              wr_ok;
  logic              addr_hit;
  logic [31:0]       rd_mux;
  logic              start;
  cbx_cmd_t          cmd_in;
  logic              two_cycle;
  logic              taken_now;
  logic [7:0]        shift_res;
  logic              shift_c;
  logic              is_shift;
  logic [15:0]       sel_ptr;
  logic [15:0]       k_ext;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------

  // Access phase and the edge at which it completes
  assign apb_acc = psel & penable;
  assign take    = apb_acc & pready;
  // Error flag was registered with ready, so it is valid at take
  assign wr_ok   = take & pwrite & ~pslverr;

  // Address decode and read mux
  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    if (paddr == CMD_OFS) begin
      rd_mux = cmd_q;
    end else if (paddr == STAT_OFS) begin
      rd_mux = {16'h0000, cyc_last, 7'h00, busy};
    end else if (paddr == STATUS_REGISTER_OFS) begin
      rd_mux = {24'h000000, status_flags};
    end else if (paddr == PC_OFS) begin
      rd_mux = {16'h0000, prog_count};
    end else if (paddr == RD_OFS) begin
      rd_mux = {24'h000000, rd};
    end else if (paddr == RR_OFS) begin
      rd_mux = {24'h000000, rr};
    end else if (paddr == XPTR_OFS) begin
      rd_mux = {16'h0000, xptr};
    end else if (paddr == YPTR_OFS) begin
      rd_mux = {16'h0000, yptr};
    end else if (paddr == MADDR_OFS) begin
      rd_mux[DM_AW-1:0] = maddr;
    end else if (paddr == MDATA_OFS) begin
      rd_mux = {24'h000000, dmem[maddr]};
    end else if (paddr == IOADDR_OFS) begin
      rd_mux[IO_AW-1:0] = ioaddr;
    end else if (paddr == IODATA_OFS) begin
      rd_mux = {24'h000000, iomem[ioaddr]};
    end else begin
      addr_hit = 1'b0;
    end
  end

  // One wait state: ready rises on the second access cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_acc & ~pready;
      // Writes during a two-cycle op are refused to keep operands stable
      pslverr <= apb_acc & ~pready & (~addr_hit | (pwrite & busy));
      if (apb_acc && !pready && !pwrite) begin
        prdata <= addr_hit ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign cmd_in  = cbx_cmd_t'(pwdata);
  assign start   = wr_ok & (paddr == CMD_OFS);
  assign k_ext   = {{8{cmd_q.k_ofs[7]}}, cmd_q.k_ofs};
  assign sel_ptr = cmd_in.ptr_sel ? yptr : xptr;
  assign is_shift = (cmd_in.op == OP_LSL) || (cmd_in.op == OP_LSR) ||
                    (cmd_in.op == OP_ASR) || (cmd_in.op == OP_ROL) ||
                    (cmd_in.op == OP_ROR);

  assign taken_now = ((cmd_in.op == OP_BR_IRQ_ON) && status_flags[FLAG_I]) ||
                     ((cmd_in.op == OP_BR_IRQ_OFF) && !status_flags[FLAG_I]);

  assign two_cycle = taken_now || (cmd_in.op == OP_IO_SET) ||
                     (cmd_in.op == OP_IO_CLR) || (cmd_in.op == OP_LD);

  // Shift and rotate results from the current operand
  always_comb begin
    shift_res = rd;
    shift_c   = status_flags[FLAG_C];
    case (cmd_in.op)
      OP_LSL: begin
        shift_res = {rd[6:0], 1'b0};
        shift_c   = rd[7];
      end
      OP_LSR: begin
        shift_res = {1'b0, rd[7:1]};
        shift_c   = rd[0];
      end
      OP_ASR: begin
        shift_res = {rd[7], rd[7:1]};
        shift_c   = rd[0];
      end
      OP_ROL: begin
        shift_res = {rd[6:0], status_flags[FLAG_C]};
        shift_c   = rd[7];
      end
      OP_ROR: begin
        shift_res = {status_flags[FLAG_C], rd[7:1]};
        shift_c   = rd[0];
      end
      default: begin
        shift_res = rd;
        shift_c   = status_flags[FLAG_C];
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  // Second cycle only for two-cycle ops; busy mirrors it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state    <= ST_IDLE;
      busy     <= 1'b0;
      cmd_q    <= '0;
      cyc_last <= 8'h00;
      br_taken <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            cmd_q    <= cmd_in;
            br_taken <= taken_now;
            cyc_last <= two_cycle ? CYC_TWO : CYC_ONE;
            if (two_cycle) begin
              state <= ST_SECOND;
              busy  <= 1'b1;
            end
          end
        end
        ST_SECOND: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // Program counter advances when each op retires
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prog_count <= PC_RST;
    end else if (wr_ok && paddr == PC_OFS) begin
      prog_count <= pwdata[15:0];
    end else if (start && !two_cycle) begin
      prog_count <= prog_count + 16'h0001;
    end else if (state == ST_SECOND) begin
      prog_count <= br_taken ? prog_count + k_ext + 16'h0001
                             : prog_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      status_flags <= STATUS_REGISTER_RST;
    end else if (wr_ok && paddr == STATUS_REGISTER_OFS) begin
      status_flags <= pwdata[7:0];
    end else if (start) begin
      if (is_shift) begin
        status_flags[FLAG_Z] <= (shift_res == 8'h00);
        status_flags[FLAG_C] <= shift_c;
        status_flags[FLAG_N] <= shift_res[7];
        status_flags[FLAG_V] <= shift_res[7] ^ shift_c;
      end else if (cmd_in.op == OP_FLAG_SET) begin
        status_flags[cmd_in.bit_sel] <= 1'b1;
      end else if (cmd_in.op == OP_FLAG_CLR) begin
        status_flags[cmd_in.bit_sel] <= 1'b0;
      end else if (cmd_in.op == OP_BST) begin
        status_flags[FLAG_T] <= rr[cmd_in.bit_sel];
      end
    end
  end

  // ----------------------------------------------------------------
  // Operand registers
  // ----------------------------------------------------------------

  // Destination register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd <= 8'h00;
    end else if (wr_ok && paddr == RD_OFS) begin
      rd <= pwdata[7:0];
    end else if (start && is_shift) begin
      rd <= shift_res;
    end else if (start && cmd_in.op == OP_SWAP) begin
      rd <= {rd[3:0], rd[7:4]};
    end else if (start && cmd_in.op == OP_BLD) begin
      rd[cmd_in.bit_sel] <= status_flags[FLAG_T];
    end else if (state == ST_SECOND && cmd_q.op == OP_LD) begin
      rd <= dmem[ld_addr];
    end
  end

  // Source register, software loaded only
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rr <= 8'h00;
    end else if (wr_ok && paddr == RR_OFS) begin
      rr <= pwdata[7:0];
    end
  end

  // Pointers move in the first load cycle; address latched beside them
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      xptr    <= PTR_RST;
      yptr    <= PTR_RST;
      ld_addr <= '0;
    end else if (wr_ok && paddr == XPTR_OFS) begin
      xptr <= pwdata[15:0];
    end else if (wr_ok && paddr == YPTR_OFS) begin
      yptr <= pwdata[15:0];
    end else if (start && cmd_in.op == OP_LD) begin
      if (cmd_in.ptr_mode == PTR_PRE) begin
        ld_addr <= DM_AW'(sel_ptr - 16'h0001);
        if (cmd_in.ptr_sel) begin
          yptr <= yptr - 16'h0001;
        end else begin
          xptr <= xptr - 16'h0001;
        end
      end else begin
        ld_addr <= sel_ptr[DM_AW-1:0];
        if (cmd_in.ptr_mode == PTR_POST) begin
          if (cmd_in.ptr_sel) begin
            yptr <= yptr + 16'h0001;
          end else begin
            xptr <= xptr + 16'h0001;
          end
        end
      end
    end
  end

  // Memory window addresses
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      maddr  <= '0;
      ioaddr <= '0;
    end else begin
      if (wr_ok && paddr == MADDR_OFS) begin
        maddr <= pwdata[DM_AW-1:0];
      end
      if (wr_ok && paddr == IOADDR_OFS) begin
        ioaddr <= pwdata[IO_AW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Data memory and I/O space
  // ----------------------------------------------------------------

  // Data memory, filled by software; contents not reset
  always_ff @(posedge mclk) begin
    if (wr_ok && paddr == MDATA_OFS) begin
      dmem[maddr] <= pwdata[7:0];
    end
  end

  // I/O space; only bit b changes on set or clear
  always_ff @(posedge mclk) begin
    if (wr_ok && paddr == IODATA_OFS) begin
      iomem[ioaddr] <= pwdata[7:0];
    end else if (state == ST_SECOND && cmd_q.op == OP_IO_SET) begin
      iomem[cmd_q.io_addr[IO_AW-1:0]][cmd_q.bit_sel] <= 1'b1;
    end else if (state == ST_SECOND && cmd_q.op == OP_IO_CLR) begin
      iomem[cmd_q.io_addr[IO_AW-1:0]][cmd_q.bit_sel] <= 1'b0;
    end
  end

endmodule

// *** tb/cbx_exec_asserts.sv ***
// Concurrent checks on the ports of the execution unit
`timescale 1ns/1ps

module cbx_exec_asserts
  import cbx_pkg::*;
(
  input wire logic        mclk,         // Clock
  input wire logic        resetn,       // Reset, low
  input wire logic        psel,         // Select
  input wire logic        penable,      // Enable
  input wire logic        pwrite,       // Direction
  input wire logic [7:0]  paddr,        // Address
  input wire logic [31:0] pwdata,       // Write data
  input wire logic [31:0] prdata,       // Read data
  input wire logic        pready,       // Ready
  input wire logic        pslverr,      // Error
  input wire logic        busy,         // Second cycle
  input wire logic [7:0]  status_flags, // Flags
  input wire logic [15:0] prog_count    // PC
);
  // ------------------------------------------------------------
  // Command snapshot
  // ------------------------------------------------------------
  cbx_cmd_t    cw;
  logic        cmd;
  logic [15:0] pc_at;
  logic [15:0] k_at;
  logic [7:0]  f_at;
  logic [2:0]  b_at;

  // A command lands at the edge that samples pready
  assign cw  = pwdata;
  assign cmd = psel && penable && pready && pwrite && !pslverr &&
               paddr == CMD_OFS;

  // Held until the op retires; no new command can land sooner
  always_ff @(posedge mclk) begin
    if (cmd) begin
      pc_at <= prog_count;
      k_at  <= {{8{cw.k_ofs[7]}}, cw.k_ofs};
      f_at  <= status_flags;
      b_at  <= cw.bit_sel;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Two-cycle op: busy for one cycle, then retired
  sequence s_two;
    busy ##1 (!busy && status_flags == f_at);
  endsequence
  sequence s_jump;
    s_two ##0 prog_count == pc_at + k_at + 16'h0001;
  endsequence

  AST_BR_TAKEN: assert property (
    cmd && ((cw.op == OP_BR_IRQ_ON && status_flags[FLAG_I]) ||
    (cw.op == OP_BR_IRQ_OFF && !status_flags[FLAG_I])) |=> s_jump)
    else $error("taken branch target or timing wrong");
  AST_BR_NOT: assert property (
    cmd && ((cw.op == OP_BR_IRQ_ON && !status_flags[FLAG_I]) ||
    (cw.op == OP_BR_IRQ_OFF && status_flags[FLAG_I])) |=>
    !busy && prog_count == pc_at + 16'h0001 && status_flags == f_at)
    else $error("untaken branch wrong");
  AST_IO_TWO: assert property (
    cmd && cw.op inside {OP_IO_SET, OP_IO_CLR} |=> s_two)
    else $error("io bit op timing or flags wrong");
  AST_LD_TWO: assert property (
    cmd && cw.op == OP_LD |=> s_two ##0 prog_count == pc_at + 16'h0001)
    else $error("load timing or flags wrong");
  AST_SHIFT: assert property (
    cmd && cw.op >= OP_LSL && cw.op <= OP_ROR |=> !busy &&
    status_flags[FLAG_V] == (status_flags[FLAG_N] ^ status_flags[FLAG_C])
    && status_flags[7:4] == f_at[7:4])
    else $error("shift flags wrong");
  AST_FSET: assert property (
    cmd && cw.op == OP_FLAG_SET |=>
    status_flags == (f_at | (8'h01 << b_at)))
    else $error("flag set wrong");
  AST_FCLR: assert property (
    cmd && cw.op == OP_FLAG_CLR |=>
    status_flags == (f_at & ~(8'h01 << b_at)))
    else $error("flag clear wrong");
  AST_BST: assert property (
    cmd && cw.op == OP_BST |=> !busy &&
    {status_flags[7], status_flags[5:0]} == {f_at[7], f_at[5:0]})
    else $error("bit store touched other flags");
endmodule

bind cbx_exec cbx_exec_asserts u_chk (.mclk(mclk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .busy(busy), .status_flags(status_flags),
  .prog_count(prog_count));

// *** tb/tb_cpu_bit_shift_flag_load_exec.sv ***
// Self-checking bench for the execution unit
`timescale 1ns/1ps

module tb_cpu_bit_shift_flag_load_exec;
  import cbx_pkg::*;
  // ------------------------------------------------------------
  // Signals and state
  // ------------------------------------------------------------
  logic        mclk = 0, resetn = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, busy, e;
  logic [7:0]  status_flags, s, d, r, v, a;
  logic [15:0] prog_count, pc, p, ex;
  logic [39:0] m;
  cbx_cmd_t    c;
  int          n_mismatch, checks_done, cyc, i;
  cbx_op_t     cop [6] = '{OP_BR_IRQ_ON, OP_BR_IRQ_OFF, OP_LSL,
                           OP_ASR, OP_ROR, OP_ROL};
  logic [7:0]  cs [6] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff};
  logic [7:0]  cd [6] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h01, 8'h80};

  cbx_exec u_dut (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
    .status_flags(status_flags), .prog_count(prog_count));

  // Clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask

  // One APB transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] dd, output logic [31:0] qq,
                     output logic ee);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    qq = prdata;
    ee = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] dd);
    logic [31:0] qq;
    logic        ee;
    apb(1'b1, ad, dd, qq, ee);
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] qq);
    logic ee;
    apb(1'b0, ad, 32'h0, qq, ee);
  endtask

  // Busy is seen one edge after the command lands
  task automatic exec(input cbx_cmd_t cc, input logic two);
    wr(CMD_OFS, cc);
    @(posedge mclk);
    chk("busy", two, busy);
  endtask

  // Expected {cycles, pc, flags, rd} for one-register ops
  function automatic logic [39:0] model(cbx_cmd_t k, logic [7:0] fs,
      logic [7:0] rv, logic [7:0] sv, logic [15:0] pv);
    logic [7:0] o, f, n;
    logic       cy, tk;
    o = rv; f = fs; cy = fs[0]; n = CYC_ONE; tk = 1'b0;
    case (k.op)
      OP_LSL: {cy, o} = {rv, 1'b0};
      OP_LSR: {o, cy} = {1'b0, rv};
      OP_ASR: {o, cy} = {rv[7], rv};
      OP_ROL: {cy, o} = {rv, fs[0]};
      OP_ROR: {o, cy} = {fs[0], rv};
      OP_SWAP: o = {rv[3:0], rv[7:4]};
      OP_FLAG_SET: f[k.bit_sel] = 1'b1;
      OP_FLAG_CLR: f[k.bit_sel] = 1'b0;
      OP_BST: f[FLAG_T] = sv[k.bit_sel];
      OP_BLD: o[k.bit_sel] = fs[FLAG_T];
      OP_BR_IRQ_ON: tk = fs[FLAG_I];
      OP_BR_IRQ_OFF: tk = !fs[FLAG_I];
      default: ;
    endcase
    if (k.op >= OP_LSL && k.op <= OP_ROR)
      f[3:0] = {o[7] ^ cy, o[7], o == 8'h00, cy};
    if (tk) begin
      n = CYC_TWO;
      pv = pv + {{8{k.k_ofs[7]}}, k.k_ofs};
    end
    return {n, pv + 16'h0001, f, o};
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(38432));
    pc = PC_RST;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rd(STATUS_REGISTER_OFS, q); chk("status_register_rst", STATUS_REGISTER_RST, q);
    rd(PC_OFS, q); chk("pc_rst", PC_RST, q);
    rd(STAT_OFS, q); chk("stat_rst", 32'h0, q);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped_err", 1'b1, e);
    chk("unmapped_data", 32'h0, q);
    $display("test reset done");
    // Corner cases first, then random ops incl. unknown codes
    for (i = 0; i < 60; i++) begin
      c = $urandom;
      s = 8'($urandom);
      d = 8'($urandom);
      r = 8'($urandom);
      if (c.op inside {OP_IO_SET, OP_IO_CLR, OP_LD}) c.op = 5'h1f;
      if (i < 6) begin
        c.op = cop[i];
        s = cs[i];
        d = cd[i];
        c.k_ofs = 8'h80;
      end
      wr(STATUS_REGISTER_OFS, s);
      wr(RD_OFS, d);
      wr(RR_OFS, r);
      m = model(c, s, d, r, pc);
      exec(c, m[39:32] == CYC_TWO);
      rd(RD_OFS, q); chk("rd", m[7:0], q);
      rd(STATUS_REGISTER_OFS, q); chk("status_register", m[15:8], q);
      rd(PC_OFS, q); chk("pc", m[31:16], q);
      rd(STAT_OFS, q); chk("cycles", m[39:32], q[15:8]);
      pc = m[31:16];
    end
    $display("test ops done");
    for (i = 0; i < 8; i++) begin
      c = '0;
      a = 8'($urandom_range(63, 0));
      v = 8'($urandom);
      s = 8'($urandom);
      c.op = i[0] ? OP_IO_CLR : OP_IO_SET;
      c.io_addr = a[5:0];
      c.bit_sel = 3'($urandom);
      wr(IOADDR_OFS, a);
      wr(IODATA_OFS, v);
      wr(STATUS_REGISTER_OFS, s);
      exec(c, 1'b1);
      v[c.bit_sel] = !i[0];
      pc = pc + 16'h0001;
      rd(IODATA_OFS, q); chk("io_data", v, q);
      rd(STATUS_REGISTER_OFS, q); chk("io_status_register", s, q);
      rd(PC_OFS, q); chk("io_pc", pc, q);
    end
    $display("test io done");
    // Plain, post-increment, pre-decrement on X then Y
    for (i = 0; i < 6; i++) begin
      c = '0;
      c.op = OP_LD;
      c.ptr_mode = 2'(i % 3);
      c.ptr_sel = i > 2;
      p = (i == 2) ? 16'h0000 : 16'($urandom_range(255, 0));
      ex = (c.ptr_mode == PTR_PRE) ? p - 16'h0001 : p;
      v = 8'($urandom);
      s = 8'($urandom);
      wr(MADDR_OFS, ex[7:0]);
      wr(MDATA_OFS, v);
      wr(STATUS_REGISTER_OFS, s);
      wr(c.ptr_sel ? YPTR_OFS : XPTR_OFS, p);
      exec(c, 1'b1);
      if (c.ptr_mode == PTR_POST) ex = p + 16'h0001;
      pc = pc + 16'h0001;
      rd(RD_OFS, q); chk("ld_rd", v, q);
      rd(c.ptr_sel ? YPTR_OFS : XPTR_OFS, q);
      chk("ld_ptr", ex, q);
      rd(STATUS_REGISTER_OFS, q); chk("ld_status_register", s, q);
      rd(PC_OFS, q); chk("ld_pc", pc, q);
    end
    $display("test load done");
    report_and_stop();
  end
endmodule
